// [dhis_params.svh]
// Purpose: Constants for the display host interface select block
// Assumes: Included by bare name
// Notes:   Strap codes are {proto_sel_hi, proto_sel_lo}
`ifndef DHIS_PARAMS_SVH
`define DHIS_PARAMS_SVH
`define DHIS_STRAP_I2C      2'h2
`define DHIS_STRAP_SER4     2'h0
`define DHIS_STRAP_PAR_EN   2'h1
`define DHIS_STRAP_PAR_RW   2'h3
`define DHIS_SER_BITS       4'h8
`define DHIS_I2C_ADDR_BASE  7'h3C
`define DHIS_READ_RESET     8'h00
`endif

// [dhis_pkg.sv]
// Purpose: Types for the display host interface select block
// Assumes: Nothing
// Notes:   Constants live in dhis_params.svh
package dhis_pkg;
	typedef enum logic [1:0] {
		DHIS_MODE_SER4   = 2'b00,
		DHIS_MODE_PAR_EN = 2'b01,
		DHIS_MODE_I2C    = 2'b10,
		DHIS_MODE_PAR_RW = 2'b11
	} dhis_mode_t;

	typedef struct packed {
		logic       is_data;
		logic [7:0] value;
	} dhis_byte_t;
endpackage

// [dhis_ser_rx.sv]
// Purpose: Four-wire serial byte receiver
// Assumes: Serial clock and data already in the system clock domain
// Notes:   Partial bytes are dropped when the select goes away
`timescale 1ns/1ps
`include "dhis_params.svh"
module dhis_ser_rx (
	// Clock and reset
	input  wire logic              clock_i,
	input  wire logic              rst_b_i,
	// Link
	input  wire logic              enable_i,
	input  wire logic              sclk_i,
	input  wire logic              serial_data_in_i,
	input  wire logic              dc_i,
	// Received byte
	output logic                   byte_valid_o,
	output dhis_pkg::dhis_byte_t   byte_o
);
	logic                 sclk_ff;
	logic [3:0]           cnt_ff;
	logic [7:0]           shift_ff;
	logic                 valid_ff;
	dhis_pkg::dhis_byte_t byte_ff;
	logic                 rise;
	logic [7:0]           nxt_shift;

	assign rise      = sclk_i & ~sclk_ff;
	assign nxt_shift = {shift_ff[6:0], serial_data_in_i};

	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			sclk_ff <= 1'b0;
		end else begin
			sclk_ff <= sclk_i;
		end
	end

	// ************************************************
	// Bit counting and shifting
	// ************************************************
	always_ff @(posedge clock_i) begin
		if (!rst_b_i || !enable_i) begin
			cnt_ff   <= 4'h0;
			shift_ff <= 8'h00;
		end else if (rise) begin
			shift_ff <= nxt_shift;
			cnt_ff   <= (cnt_ff == `DHIS_SER_BITS - 4'h1) ? 4'h0 : cnt_ff + 4'h1;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			valid_ff <= 1'b0;
			byte_ff  <= '0;
		end else begin
			valid_ff <= enable_i && rise && (cnt_ff == `DHIS_SER_BITS - 4'h1);
			if (enable_i && rise && (cnt_ff == `DHIS_SER_BITS - 4'h1)) begin
				byte_ff <= '{is_data: dc_i, value: nxt_shift};
			end
		end
	end

	assign byte_valid_o = valid_ff;
	assign byte_o       = byte_ff;
endmodule

// [dhis_top.sv]
// Purpose: Host interface front end with strap-selected protocol
// Assumes: All pins synchronous to clock_i; I2C engine lives elsewhere
// Notes:   Parallel strobes are edge-detected once per access
//
// Behaviour
// - Straps pick I2C, four-wire serial, enable-strobe or split-strobe parallel.
// - Reset pin low holds the controller and this front end in initialisation.
// - Chip select low enables traffic; high blocks every byte, read and I2C access.
// - Parallel byte goes to display data when selector high, command when low.
// - Serial byte is display data when selector high, command when low.
// - In I2C mode the selector supplies the target address low bit.
// - Enable-strobe mode starts an access when enable is high and selected.
// - Enable-strobe direction high means read, low means write.
// - Split-strobe mode starts a read when read strobe low and selected.
// - Split-strobe mode starts a write when write strobe low, read strobe high and selected.
// - Parallel data bus is two-way, driven by the device only on reads.
// - Serial mode takes data from line 1 and clock from line 0.
`timescale 1ns/1ps
`include "dhis_params.svh"
module dhis_top (
	// Clock and reset
	input  wire logic              clock_i,
	input  wire logic              rst_b_i,
	// Straps and control pins
	input  wire logic              proto_sel_hi_i,
	input  wire logic              proto_sel_lo_i,
	input  wire logic              reset_n_in_i,
	input  wire logic              cs_n_i,
	input  wire logic              dc_i,
	input  wire logic              en_rd_n_i,
	input  wire logic              rw_wr_n_i,
	// Host data bus, split into three signals
	input  wire logic [7:0]        host_data_bus_i,
	output logic [7:0]             host_data_bus_o,
	output logic [7:0]             host_data_bus_oe_o,
	// Received bytes to the controller core
	output logic                   byte_valid_o,
	output dhis_pkg::dhis_byte_t   byte_o,
	// Read path from the controller core
	output logic                   rd_req_o,
	output logic                   rd_is_data_o,
	input  wire logic [7:0]        rd_data_i,
	// I2C engine hooks
	output logic                   i2c_active_o,
	output logic [6:0]             i2c_target_addr_o,
	output logic                   i2c_scl_o,
	output logic                   i2c_sda_in_o,
	input  wire logic              i2c_sda_drive_low_i,
	// Controller initialisation and mode
	output logic                   core_init_o,
	output dhis_pkg::dhis_mode_t   mode_o
);
	dhis_pkg::dhis_mode_t mode_ff;
	logic                 rst_ok;
	logic                 sel;
	logic                 par_acc;
	logic                 par_rd;
	logic                 par_acc_ff;
	logic                 nxt_rd_active;
	logic                 rd_active_ff;
	logic [7:0]           rd_data_ff;
	logic                 par_valid_ff;
	dhis_pkg::dhis_byte_t par_byte_ff;
	logic                 ser_valid;
	dhis_pkg::dhis_byte_t ser_byte;
	logic                 init_ff;

	// Both resets clear the front end; reset pin also drives core init
	assign rst_ok = rst_b_i & reset_n_in_i;
	assign sel    = ~cs_n_i;

	// ************************************************
	// Strap capture
	// ************************************************
	// Straps caught after release so they never feed the reset path
	always_ff @(posedge clock_i) begin
		if (!rst_ok) begin
			mode_ff <= dhis_pkg::DHIS_MODE_SER4;
		end else begin
			mode_ff <= dhis_pkg::dhis_mode_t'({proto_sel_hi_i, proto_sel_lo_i});
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			init_ff <= 1'b1;
		end else begin
			init_ff <= ~reset_n_in_i;
		end
	end

	// ************************************************
	// Parallel access decode
	// ************************************************
	always_comb begin
		par_acc = 1'b0;
		par_rd  = 1'b0;
		case (mode_ff)
			dhis_pkg::DHIS_MODE_PAR_EN: begin
				par_acc = sel & en_rd_n_i;
				par_rd  = rw_wr_n_i;
			end
			dhis_pkg::DHIS_MODE_PAR_RW: begin
				par_acc = sel & (~en_rd_n_i | ~rw_wr_n_i);
				par_rd  = ~en_rd_n_i;
			end
			default: begin
				par_acc = 1'b0;
				par_rd  = 1'b0;
			end
		endcase
	end

	// Read drive lags the strobe by one cycle at both ends; data latched at its start so the host sees stable data
	assign nxt_rd_active = par_acc & par_rd;

	always_ff @(posedge clock_i) begin
		if (!rst_ok) begin
			par_acc_ff   <= 1'b0;
			rd_active_ff <= 1'b0;
		end else begin
			par_acc_ff   <= par_acc;
			rd_active_ff <= nxt_rd_active;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rst_ok) begin
			rd_data_ff <= `DHIS_READ_RESET;
		end else if (par_acc && par_rd && !par_acc_ff) begin
			rd_data_ff <= rd_data_i;
		end
	end

	// Write byte taken once on the strobe's leading edge
	always_ff @(posedge clock_i) begin
		if (!rst_ok) begin
			par_valid_ff <= 1'b0;
			par_byte_ff  <= '0;
		end else begin
			par_valid_ff <= par_acc && !par_rd && !par_acc_ff;
			if (par_acc && !par_rd && !par_acc_ff) begin
				par_byte_ff <= '{is_data: dc_i, value: host_data_bus_i};
			end
		end
	end

	assign rd_req_o           = par_acc & par_rd & ~par_acc_ff;
	assign rd_is_data_o       = dc_i;
	assign host_data_bus_o    = rd_active_ff ? rd_data_ff : 8'h00;
	assign host_data_bus_oe_o = rd_active_ff ? 8'hFF : 8'h00;

	// ************************************************
	// Serial receiver
	// ************************************************
	dhis_ser_rx u_ser_rx (
		.clock_i      (clock_i),
		.rst_b_i      (rst_ok),
		.enable_i     (sel && mode_ff == dhis_pkg::DHIS_MODE_SER4),
		.sclk_i       (host_data_bus_i[0]),
		.serial_data_in_i       (host_data_bus_i[1]),
		.dc_i         (dc_i),
		.byte_valid_o (ser_valid),
		.byte_o       (ser_byte)
	);

	assign byte_valid_o = par_valid_ff | ser_valid;
	assign byte_o       = par_valid_ff ? par_byte_ff : ser_byte;

	// ************************************************
	// I2C hooks
	// ************************************************
	// SCL comes in on line 0 and SDA on line 1; i2c_sda_drive_low_i drives no pin here
	assign i2c_active_o      = (mode_ff == dhis_pkg::DHIS_MODE_I2C) & sel;
	assign i2c_target_addr_o = {6'(`DHIS_I2C_ADDR_BASE >> 1), dc_i};
	assign i2c_scl_o         = host_data_bus_i[0];
	assign i2c_sda_in_o      = host_data_bus_i[1];

	assign core_init_o = init_ff;
	assign mode_o      = mode_ff;
endmodule

// [dhis_asserts.sv]
// Purpose: Port checks for dhis_top
// Assumes: Bound from the bench
// Notes:   Serial framing is judged by the bench
`timescale 1ns/1ps
module dhis_asserts (
	// Clock, reset and pins
	input wire logic                 clock_i,
	input wire logic                 rst_b_i,
	input wire logic                 proto_sel_hi_i,
	input wire logic                 proto_sel_lo_i,
	input wire logic                 reset_n_in_i,
	input wire logic                 cs_n_i,
	input wire logic                 dc_i,
	input wire logic                 en_rd_n_i,
	input wire logic                 rw_wr_n_i,
	input wire logic [7:0]           host_data_bus_i,
	input wire logic [7:0]           rd_data_i,
	// Outputs
	input wire logic [7:0]           host_data_bus_o,
	input wire logic [7:0]           host_data_bus_oe_o,
	input wire logic                 byte_valid_o,
	input wire dhis_pkg::dhis_byte_t byte_o,
	input wire logic [6:0]           i2c_target_addr_o,
	input wire logic                 core_init_o,
	input wire dhis_pkg::dhis_mode_t mode_o
);
	wire sel = !cs_n_i && reset_n_in_i;
	wire p_rw = mode_o == dhis_pkg::DHIS_MODE_PAR_RW;
	wire p_en = mode_o == dhis_pkg::DHIS_MODE_PAR_EN;
	wire wr_act = sel && (p_rw ? !rw_wr_n_i && en_rd_n_i : p_en && en_rd_n_i && !rw_wr_n_i);
	wire rd_act = sel && (p_rw ? !en_rd_n_i && rw_wr_n_i : p_en && en_rd_n_i && rw_wr_n_i);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_b_i);
	sequence wr_start;
		$rose(wr_act);
	endsequence
	sequence rd_held;
		$rose(rd_act) ##1 rd_act;
	endsequence
	wr_byte_a: assert property (wr_start |=>
		byte_valid_o && byte_o == $past({dc_i, host_data_bus_i})) else $error("bad write");
	cs_ignore_a: assert property ($past(cs_n_i) |-> !byte_valid_o)
		else $error("byte while deselected");
	dc_class_a: assert property (byte_valid_o |-> byte_o.is_data == $past(dc_i))
		else $error("bad data or command flag");
	rd_data_a: assert property (rd_held |->
		host_data_bus_oe_o == 8'hFF && host_data_bus_o == $past(rd_data_i)) else $error("bad read");
	rd_drive_a: assert property (host_data_bus_oe_o != 8'h00 |-> $past(rd_act))
		else $error("bus driven outside a read");
	i2c_addr_a: assert property (mode_o == dhis_pkg::DHIS_MODE_I2C |->
		i2c_target_addr_o == {6'h1E, dc_i}) else $error("bad target address");
	mode_cap_a: assert property ($past(rst_b_i) && $past(reset_n_in_i) |->
		mode_o == $past({proto_sel_hi_i, proto_sel_lo_i})) else $error("bad mode");
	core_init_a: assert property ($past(rst_b_i) |-> core_init_o == !$past(reset_n_in_i))
		else $error("bad init");
endmodule

// [dhis_host.sv]
// Purpose: Host controller model for the display interface
// Assumes: Driven at falling clock edges
// Notes:   Released bus shows inverted junk, never the last value
`timescale 1ns/1ps
module dhis_host (
	// Clock, strap and bus return
	input  wire logic       clock_i,
	input  wire logic [1:0] strap_i,
	input  wire logic [7:0] bus_i,
	// Host pins
	output logic            cs_n_o,
	output logic            dc_o,
	output logic            en_rd_n_o,
	output logic            rw_wr_n_o,
	output logic [7:0]      bus_o
);
	initial begin
		cs_n_o = 1'b1;
		dc_o = 1'b0;
		en_rd_n_o = 1'b0;
		rw_wr_n_o = 1'b0;
		bus_o = 8'h00;
	end
	// Serial and I2C tie both strobes low
	task idle();
		en_rd_n_o = &strap_i;
		rw_wr_n_o = &strap_i;
	endtask
	task par(input logic rd, input logic s, input logic d, input logic [7:0] v, input int n,
		output logic [7:0] q);
		@(negedge clock_i);
		cs_n_o = !s;
		dc_o = d;
		bus_o = rd ? ~bus_o : v;
		en_rd_n_o = strap_i[1] ? !rd : 1'b1;
		rw_wr_n_o = strap_i[1] ? rd : rd;
		repeat (n) @(negedge clock_i);
		q = bus_i;
		cs_n_o = 1'b1;
		idle();
	endtask
	task ser(input logic d, input logic [7:0] v, input int nb);
		@(negedge clock_i);
		cs_n_o = 1'b0;
		dc_o = d;
		for (int i = 0; i < nb; i++) begin
			bus_o = {6'h00, v[7 - i], 1'b0};
			@(negedge clock_i);
			bus_o[0] = 1'b1;
			@(negedge clock_i);
		end
		bus_o = 8'h00;
		@(negedge clock_i);
		cs_n_o = 1'b1;
	endtask
endmodule

// [test_display_host_interface_select.sv]
// Purpose: Self-checking bench for dhis_top
// Assumes: Host model drives chip select, selector, strobes and bus; bench drives straps and resets
// Notes:   Expected bytes wait in a queue
`timescale 1ns/1ps
module test_display_host_interface_select;
	logic clock_i, rst_b_i, reset_n_in_i, cs_n, dc, en_rd_n, rw_wr_n, byte_valid_o, core_init_o;
	logic [1:0] strap;
	logic [7:0] rd_data_i, bus_wire, host_bus, bus_o, bus_oe, q;
	logic [6:0] i2c_addr;
	logic [8:0] v, w, exp_q[$];
	logic [1:0] codes[4] = '{2'h3, 2'h1, 2'h0, 2'h2};
	dhis_pkg::dhis_byte_t byte_o;
	dhis_pkg::dhis_mode_t mode_o;
	int n_mismatch, n_tests;
	assign bus_wire = bus_oe[0] ? bus_o : host_bus;
	dhis_top i_dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .proto_sel_hi_i(strap[1]),
		.proto_sel_lo_i(strap[0]), .reset_n_in_i(reset_n_in_i), .cs_n_i(cs_n), .dc_i(dc),
		.en_rd_n_i(en_rd_n), .rw_wr_n_i(rw_wr_n), .host_data_bus_i(bus_wire),
		.host_data_bus_o(bus_o), .host_data_bus_oe_o(bus_oe), .byte_valid_o(byte_valid_o),
		.byte_o(byte_o), .rd_req_o(), .rd_is_data_o(), .rd_data_i(rd_data_i), .i2c_active_o(),
		.i2c_target_addr_o(i2c_addr), .i2c_scl_o(), .i2c_sda_in_o(), .i2c_sda_drive_low_i(1'b0),
		.core_init_o(core_init_o), .mode_o(mode_o));
	dhis_host i_host (.clock_i(clock_i), .strap_i(strap), .bus_i(bus_wire), .cs_n_o(cs_n),
		.dc_o(dc), .en_rd_n_o(en_rd_n), .rw_wr_n_o(rw_wr_n), .bus_o(host_bus));
	task chk(input logic [8:0] got, input logic [8:0] want);
		n_tests++;
		if (got !== want) begin
			n_mismatch++;
			$display("ERROR %0t got %h want %h", $time, got, want);
		end
	endtask
	task test_done();
		if (n_mismatch == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		clock_i = 1'b0;
		forever #2.5 clock_i = ~clock_i;
	end
	always @(posedge clock_i) if (byte_valid_o === 1'b1) begin
		w = exp_q.size() ? exp_q.pop_front() : 'x;
		chk(byte_o, w);
	end
	initial begin
		repeat (5000) @(posedge clock_i);
		n_mismatch++;
		test_done();
	end
	initial begin
		void'($urandom(32'h7CE5A8B1));
		{n_mismatch, n_tests} = 0;
		{rst_b_i, strap, reset_n_in_i, rd_data_i} = {1'b0, 2'h0, 1'b1, 8'h00};
		repeat (3) @(negedge clock_i);
		rst_b_i = 1'b1;
		foreach (codes[k]) begin
			strap = codes[k];
			i_host.idle();
			repeat (2) @(negedge clock_i);
			chk({7'h00, mode_o}, {7'h00, strap});
			if (strap[0]) begin
				repeat (4) begin
					v = 9'($urandom);
					exp_q.push_back(v);
					i_host.par(1'b0, 1'b1, v[8], v[7:0], 2, q);
				end
				i_host.par(1'b0, 1'b0, 1'b1, 8'hA5, 2, q);
				rd_data_i = 8'($urandom);
				i_host.par(1'b1, 1'b1, 1'b0, 8'h00, 3, q);
				chk({1'b0, q}, {1'b0, rd_data_i});
			end else begin
				i_host.ser(1'b1, 8'hFF, 3);
				repeat (2) begin
					v = 9'($urandom);
					if (!strap[1]) exp_q.push_back(v);
					i_host.ser(v[8], v[7:0], 8);
				end
				if (strap[1]) chk({2'h0, i2c_addr}, {2'h0, 6'h1E, v[8]});
			end
			repeat (3) @(negedge clock_i);
			chk(9'(exp_q.size()), 9'h000);
		end
		reset_n_in_i = 1'b0;
		repeat (2) @(negedge clock_i);
		chk({8'h00, core_init_o}, 9'h001);
		reset_n_in_i = 1'b1;
		repeat (2) @(negedge clock_i);
		chk({8'h00, core_init_o}, 9'h000);
		test_done();
	end
endmodule
bind dhis_top dhis_asserts i_chk (.clock_i(clock_i), .rst_b_i(rst_b_i),
	.proto_sel_hi_i(proto_sel_hi_i), .proto_sel_lo_i(proto_sel_lo_i),
	.reset_n_in_i(reset_n_in_i), .cs_n_i(cs_n_i), .dc_i(dc_i), .en_rd_n_i(en_rd_n_i),
	.rw_wr_n_i(rw_wr_n_i), .host_data_bus_i(host_data_bus_i), .rd_data_i(rd_data_i),
	.host_data_bus_o(host_data_bus_o), .host_data_bus_oe_o(host_data_bus_oe_o),
	.byte_valid_o(byte_valid_o), .byte_o(byte_o), .i2c_target_addr_o(i2c_target_addr_o),
	.core_init_o(core_init_o), .mode_o(mode_o));
